// *** rtl/sdc_defines.vh ***
// constants for the sinc3 decimation channel block
`ifndef SDC_DEFINES_VH
`define SDC_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SDC_OFS_SETUP_ONE     8'h00
`define SDC_OFS_SETUP_THREE   8'h04
`define SDC_OFS_CONTROL       8'h08
`define SDC_OFS_STATUS        8'h0C
`define SDC_OFS_CHAN_BASE     8'h20
`define SDC_OFS_DATA_BASE     8'h40
`define SDC_REGION_MASK       8'hE0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SDC_RATE_LSB          0
`define SDC_REFBUF_BIT        0
`define SDC_BIASMEAS_BIT      1
`define SDC_START_BIT         0
`define SDC_STAT_RUN_BIT      0
`define SDC_STAT_SETTLED_BIT  1
`define SDC_STAT_BADRATE_BIT  2
`define SDC_STAT_COUNT_LSB    16
`define SDC_MUX_LSB           0
`define SDC_GAIN_LSB          4

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define SDC_RATE_RESET        3'h6
`define SDC_RATE_INVALID      3'h7
`define SDC_CHAN_RESET        7'h60
`define SDC_MUX_BIAS_AUX      3'h2

// ----------------------------------------------------------------
// timing and arithmetic
// ----------------------------------------------------------------
`define SDC_MOD_DIV           2
`define SDC_BASE_RATIO        12'h040
`define SDC_SETTLE_WORDS      2'h3
`define SDC_SINC_ORDER        3
`define SDC_FULL_SCALE_EXP    36

`endif

// *** rtl/sdc_result_ram.v ***
// result memory: one word per channel, registered read data
`timescale 1ns/100ps
module sdc_result_ram #(
    parameter DW = 24,
    parameter AW = 3
) (
    // clock and reset
    input  wire          clk,
    input  wire          sys_rst,
    // write port
    input  wire          wrEn,
    input  wire [AW-1:0] wrAddr,
    input  wire [DW-1:0] wrData,
    // read port
    input  wire          rdEn,
    input  wire [AW-1:0] rdAddr,
    output wire [DW-1:0] rdData
);

    reg [DW-1:0] mem [0:(1<<AW)-1];
    reg [DW-1:0] rdData_r;

    // storage write
    always @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // registered read
    always @(posedge clk) begin
        if (sys_rst) begin
            rdData_r <= {DW{1'b0}};
        end else if (rdEn) begin
            rdData_r <= mem[rdAddr];
        end
    end

    assign rdData = rdData_r;

endmodule // sdc_result_ram

// *** rtl/sdc_top.v ***
// sinc3 decimation channels with ahb-lite register access
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`include "sdc_defines.vh"

module sdc_top #(
    parameter NCH = 8
) (
    // clock and reset
    input  wire           clk,
    input  wire           sys_rst,
    // ahb-lite slave
    input  wire           hsel,
    input  wire [31:0]    haddr,
    input  wire [1:0]     htrans,
    input  wire           hwrite,
    input  wire [2:0]     hsize,
    input  wire [31:0]    hwdata,
    input  wire           hready,
    output wire           hreadyout,
    output wire           hresp,
    output wire [31:0]    hrdata,
    // modulator side
    input  wire [NCH-1:0] modBit,
    output wire           modSampleEn,
    // analog front-end controls
    output wire [3*NCH-1:0] chanGain,
    output wire [3*NCH-1:0] chanMux,
    output wire [NCH-1:0] chanBiasMeasure,
    output wire           refBufferPowerdownN,
    // conversion status
    output wire           dataReady
);

    localparam AW = 40;
    localparam ST_IDLE  = 2'b01;
    localparam ST_WRITE = 2'b10;

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------

    // decimation ratio minus one for a rate code
    function [11:0] ratioM1;
        input [2:0] code;
        begin
            ratioM1 = (`SDC_BASE_RATIO << code) - 12'h001;
        end
    endfunction

    // scale a sinc3 sum of +-N^3 to a signed 24-bit word
    function [23:0] scaleWord;
        input [AW-1:0] acc;
        input [2:0]    code;
        reg   [AW-1:0] sh;
        begin
            sh = acc << (`SDC_FULL_SCALE_EXP - 18 - 3 * code);
            if (!sh[AW-1] && (sh[AW-2:`SDC_FULL_SCALE_EXP] != 3'h0)) begin
                scaleWord = 24'h7FFFFF;
            end else begin
                scaleWord = sh[`SDC_FULL_SCALE_EXP:`SDC_FULL_SCALE_EXP-23];
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg [2:0]       rateSel_r;
    reg             refBufOn_r;
    reg             biasMeasureSel_r;
    reg             start_r;
    reg             startPrev_r;
    reg [7*NCH-1:0] chanSet_r;
    reg             running_r;
    reg             settled_r;
    reg             badRate_r;
    reg [15:0]      wordCount_r;
    reg [2:0]       activeRate_r;

    // ahb pipeline state
    reg             wrPend_r;
    reg [7:0]       wrAddr_r;
    reg             rdMem_r;
    reg [31:0]      rdReg_r;
    reg [31:0]      rdVal;

    // filter timing
    reg             modPhase_r;
    reg [11:0]      decCnt_r;
    reg             decTick_r;
    reg [1:0]       settleCnt_r;

    // result sequencer
    reg [1:0]       state_r;
    reg [1:0]       state_nxt;
    reg [2:0]       seqCh_r;
    reg             dataReady_r;

    wire            addrPhase = hsel & hready & htrans[1];
    wire            startRise = start_r & ~startPrev_r;
    wire            modTick   = modPhase_r;
    wire            decLast   = modTick & (decCnt_r == ratioM1(activeRate_r));
    wire [AW*NCH-1:0] combFlat;
    wire            ramRdEn   = addrPhase & ~hwrite & ((haddr[7:0] & `SDC_REGION_MASK) == `SDC_OFS_DATA_BASE);
    wire [23:0]     ramRdData;
    wire [23:0]     seqWord   = scaleWord(combFlat[seqCh_r*AW +: AW], activeRate_r);
    wire            seqWrite  = state_r[1];

    // ----------------------------------------------------------------
    // ahb-lite slave
    // ----------------------------------------------------------------

    // zero-wait slave, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdMem_r ? {8'h00, ramRdData} : rdReg_r;

    // read decode of control and status words
    always @* begin
        rdVal = 32'h0000_0000;
        case (haddr[7:0] & `SDC_REGION_MASK)
            8'h00: begin
                case (haddr[7:0])
                    `SDC_OFS_SETUP_ONE:   rdVal[`SDC_RATE_LSB +: 3] = rateSel_r;
                    `SDC_OFS_SETUP_THREE: begin
                        rdVal[`SDC_REFBUF_BIT]   = refBufOn_r;
                        rdVal[`SDC_BIASMEAS_BIT] = biasMeasureSel_r;
                    end
                    `SDC_OFS_CONTROL:     rdVal[`SDC_START_BIT] = start_r;
                    `SDC_OFS_STATUS: begin
                        rdVal[`SDC_STAT_RUN_BIT]        = running_r;
                        rdVal[`SDC_STAT_SETTLED_BIT]    = settled_r;
                        rdVal[`SDC_STAT_BADRATE_BIT]    = badRate_r;
                        rdVal[`SDC_STAT_COUNT_LSB +: 16] = wordCount_r;
                    end
                    default: rdVal = 32'h0000_0000;
                endcase
            end
            `SDC_OFS_CHAN_BASE: begin
                if (haddr[4:2] < NCH) begin
                    rdVal[6:0] = chanSet_r[haddr[4:2]*7 +: 7];
                end
            end
            default: rdVal = 32'h0000_0000;
        endcase
    end

    // address phase capture and read data register
    always @(posedge clk) begin
        if (sys_rst) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 8'h00;
            rdMem_r  <= 1'b0;
            rdReg_r  <= 32'h0000_0000;
        end else if (hready) begin
            wrPend_r <= addrPhase & hwrite;
            wrAddr_r <= haddr[7:0];
            rdMem_r  <= ramRdEn & (haddr[4:2] < NCH);
            rdReg_r  <= (addrPhase & ~hwrite) ? rdVal : 32'h0000_0000;
        end
    end

    // register writes in the data phase
    always @(posedge clk) begin
        if (sys_rst) begin
            rateSel_r        <= `SDC_RATE_RESET;
            refBufOn_r       <= 1'b0;
            biasMeasureSel_r <= 1'b0;
            start_r          <= 1'b0;
            chanSet_r        <= {NCH{`SDC_CHAN_RESET}};
        end else if (wrPend_r) begin
            case (wrAddr_r & `SDC_REGION_MASK)
                8'h00: begin
                    case (wrAddr_r)
                        `SDC_OFS_SETUP_ONE:   rateSel_r <= hwdata[`SDC_RATE_LSB +: 3];
                        `SDC_OFS_SETUP_THREE: begin
                            refBufOn_r       <= hwdata[`SDC_REFBUF_BIT];
                            biasMeasureSel_r <= hwdata[`SDC_BIASMEAS_BIT];
                        end
                        `SDC_OFS_CONTROL:     start_r <= hwdata[`SDC_START_BIT];
                        default:              start_r <= start_r;
                    endcase
                end
                `SDC_OFS_CHAN_BASE: begin
                    if (wrAddr_r[4:2] < NCH) begin
                        chanSet_r[wrAddr_r[4:2]*7 +: 7] <= hwdata[6:0];
                    end
                end
                default: start_r <= start_r;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // front-end control outputs
    // ----------------------------------------------------------------
    assign refBufferPowerdownN = refBufOn_r;

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : gCtl
            assign chanGain[3*g +: 3] = chanSet_r[7*g+`SDC_GAIN_LSB +: 3];
            assign chanMux[3*g +: 3]  = chanSet_r[7*g+`SDC_MUX_LSB +: 3];
            // aux bias input routed only with both settings made
            assign chanBiasMeasure[g] = biasMeasureSel_r &
                                        (chanSet_r[7*g+`SDC_MUX_LSB +: 3] == `SDC_MUX_BIAS_AUX);
        end
    endgenerate

    // ----------------------------------------------------------------
    // run control and decimation timing
    // ----------------------------------------------------------------

    // start edge latches the shared rate; invalid code refuses to run
    always @(posedge clk) begin
        if (sys_rst) begin
            startPrev_r  <= 1'b0;
            running_r    <= 1'b0;
            badRate_r    <= 1'b0;
            activeRate_r <= `SDC_RATE_RESET;
        end else begin
            startPrev_r <= start_r;
            if (!start_r) begin
                running_r <= 1'b0;
            end else if (startRise) begin
                activeRate_r <= rateSel_r;
                running_r    <= (rateSel_r != `SDC_RATE_INVALID);
                badRate_r    <= (rateSel_r == `SDC_RATE_INVALID);
            end
        end
    end

    // modulator sample enable at half the clock rate
    always @(posedge clk) begin
        if (sys_rst) begin
            modPhase_r <= 1'b0;
        end else if (!running_r) begin
            modPhase_r <= 1'b0;
        end else begin
            modPhase_r <= ~modPhase_r;
        end
    end

    assign modSampleEn = modTick;

    // decimation counter: N = 64 << code modulator samples per word
    always @(posedge clk) begin
        if (sys_rst) begin
            decCnt_r  <= 12'h000;
            decTick_r <= 1'b0;
        end else begin
            decTick_r <= running_r & decLast;
            if (!running_r) begin
                decCnt_r <= 12'h000;
            end else if (modTick) begin
                decCnt_r <= decLast ? 12'h000 : decCnt_r + 12'h001;
            end
        end
    end

    // ----------------------------------------------------------------
    // per-channel sinc3 filters
    // ----------------------------------------------------------------
    generate
        for (g = 0; g < NCH; g = g + 1) begin : gSinc
            reg  [AW-1:0] int1_r;
            reg  [AW-1:0] int2_r;
            reg  [AW-1:0] int3_r;
            reg  [AW-1:0] dly1_r;
            reg  [AW-1:0] dly2_r;
            reg  [AW-1:0] dly3_r;
            reg  [AW-1:0] comb_r;
            wire [AW-1:0] inVal = modBit[g] ? {{(AW-1){1'b0}}, 1'b1} : {AW{1'b1}};
            wire [AW-1:0] diff1 = int3_r - dly1_r;
            wire [AW-1:0] diff2 = diff1 - dly2_r;
            wire [AW-1:0] diff3 = diff2 - dly3_r;

            // three integrators at the modulator rate
            always @(posedge clk) begin
                if (sys_rst || startRise || !running_r) begin
                    int1_r <= {AW{1'b0}};
                    int2_r <= {AW{1'b0}};
                    int3_r <= {AW{1'b0}};
                end else if (modTick) begin
                    int1_r <= int1_r + inVal;
                    int2_r <= int2_r + int1_r;
                    int3_r <= int3_r + int2_r;
                end
            end

            // three combs at the output rate put zeros at k*fout
            always @(posedge clk) begin
                if (sys_rst || startRise || !running_r) begin
                    dly1_r <= {AW{1'b0}};
                    dly2_r <= {AW{1'b0}};
                    dly3_r <= {AW{1'b0}};
                    comb_r <= {AW{1'b0}};
                end else if (decLast) begin
                    dly1_r <= int3_r;
                    dly2_r <= diff1;
                    dly3_r <= diff2;
                    comb_r <= diff3;
                end
            end

            assign combFlat[g*AW +: AW] = comb_r;
        end
    endgenerate

    // ----------------------------------------------------------------
    // settling and result sequencer
    // ----------------------------------------------------------------

    // next state of the write sequencer
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (decTick_r && settleCnt_r == `SDC_SETTLE_WORDS) begin
                    state_nxt = ST_WRITE;
                end
            end
            ST_WRITE: begin
                if (seqCh_r == NCH - 1) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // words before settling are dropped, then each channel is stored
    always @(posedge clk) begin
        if (sys_rst) begin
            state_r     <= ST_IDLE;
            seqCh_r     <= 3'h0;
            settleCnt_r <= 2'h0;
            settled_r   <= 1'b0;
            wordCount_r <= 16'h0000;
            dataReady_r <= 1'b0;
        end else if (startRise || !running_r) begin
            state_r     <= ST_IDLE;
            seqCh_r     <= 3'h0;
            settleCnt_r <= 2'h0;
            settled_r   <= startRise ? 1'b0 : settled_r;
            dataReady_r <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            dataReady_r <= 1'b0;
            if (decTick_r && settleCnt_r != `SDC_SETTLE_WORDS) begin
                settleCnt_r <= settleCnt_r + 2'h1;
            end
            if (seqWrite) begin
                seqCh_r <= (seqCh_r == NCH - 1) ? 3'h0 : seqCh_r + 3'h1;
                if (seqCh_r == NCH - 1) begin
                    dataReady_r <= 1'b1;
                    settled_r   <= 1'b1;
                    wordCount_r <= wordCount_r + 16'h0001;
                end
            end
        end
    end

    assign dataReady = dataReady_r;

    // ----------------------------------------------------------------
    // conversion result store, 24-bit per channel
    // ----------------------------------------------------------------
    sdc_result_ram #(
        .DW (24),
        .AW (3)
    ) uResults (
        .clk     (clk),
        .sys_rst (sys_rst),
        .wrEn    (seqWrite),
        .wrAddr  (seqCh_r),
        .wrData  (seqWord),
        .rdEn    (ramRdEn),
        .rdAddr  (haddr[4:2]),
        .rdData  (ramRdData)
    );

endmodule // sdc_top

// *** dv/sdc_mod_model.sv ***
// modulator stand-in presenting a fixed level per channel
`timescale 1ns/100ps
module sdc_mod_model #(
    parameter NCH = 2
) (
    // strobe from the block
    input  wire           modSampleEn,
    // level each channel presents
    input  wire [NCH-1:0] level,
    // bitstreams into the block
    output wire [NCH-1:0] modBit
);
    // true level only in the strobe cycle, inverted otherwise to expose a stray sample
    assign modBit = modSampleEn ? level : ~level;
endmodule // sdc_mod_model

// *** dv/sdc_top_properties.sv ***
// port-level assertions for the sinc3 decimation block
`timescale 1ns/100ps
`include "sdc_defines.vh"
module sdc_top_properties #(
    parameter NCH = 8
) (
    // clock and reset
    input wire             clk,
    input wire             sys_rst,
    // bus
    input wire             hsel,
    input wire [31:0]      haddr,
    input wire [1:0]       htrans,
    input wire             hwrite,
    input wire [31:0]      hwdata,
    input wire             hready,
    input wire             hreadyout,
    input wire             hresp,
    input wire [31:0]      hrdata,
    // stream and controls
    input wire             modSampleEn,
    input wire [3*NCH-1:0] chanGain,
    input wire [3*NCH-1:0] chanMux,
    input wire [NCH-1:0]   chanBiasMeasure,
    input wire             refBufferPowerdownN,
    input wire             dataReady
);
    reg       wrPh_r;
    reg [7:0] addr_r;
    genvar    k;
    // track write data phases and their address
    always @(posedge clk) begin
        if (sys_rst) begin
            wrPh_r <= 1'b0;
            addr_r <= 8'h00;
        end else begin
            wrPh_r <= hsel & hready & htrans[1] & hwrite;
            if (hsel & hready & htrans[1]) begin
                addr_r <= haddr[7:0];
            end
        end
    end
    a_ready_out: assert property (@(posedge clk) disable iff (sys_rst) (hsel && htrans[1]) |-> hreadyout)
        else $error("wait state inserted");
    a_okay_resp: assert property (@(posedge clk) disable iff (sys_rst) (hsel && htrans[1]) |=> (!hresp)[*2])
        else $error("error response given");
    a_sample_gap: assert property (@(posedge clk) disable iff (sys_rst) modSampleEn |=> !modSampleEn)
        else $error("sample strobe faster than clk/2");
    a_ready_spacing: assert property (@(posedge clk) disable iff (sys_rst) dataReady |=> (!dataReady)[*8])
        else $error("data ready pulses too close");
    generate
        for (k = 0; k < NCH; k = k + 1) begin : g_bias
            a_bias_mux: assert property (@(posedge clk) disable iff (sys_rst)
                chanBiasMeasure[k] |-> chanMux[3*k+:3] == `SDC_MUX_BIAS_AUX)
                else $error("bias measure without mux 010");
        end
    endgenerate
    a_reset_quiet: assert property (@(posedge clk) disable iff (sys_rst) $fell(sys_rst) |-> !refBufferPowerdownN
        && chanBiasMeasure == {NCH{1'b0}} && !dataReady && !modSampleEn && hrdata == 32'h0)
        else $error("outputs not at reset values");
    a_gain_cause: assert property (@(posedge clk) disable iff (sys_rst) $changed(chanGain) |-> $past(wrPh_r))
        else $error("gain changed without a write");
    a_refbuf_write: assert property (@(posedge clk) disable iff (sys_rst)
        (wrPh_r && addr_r == `SDC_OFS_SETUP_THREE) |=> refBufferPowerdownN == $past(hwdata[0]))
        else $error("ref buffer bit not written");
endmodule // sdc_top_properties

bind sdc_top sdc_top_properties #(.NCH(NCH)) sdc_top_properties_i (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .modSampleEn(modSampleEn), .chanGain(chanGain), .chanMux(chanMux),
    .chanBiasMeasure(chanBiasMeasure), .refBufferPowerdownN(refBufferPowerdownN), .dataReady(dataReady));

// *** dv/tb_top.sv ***
// self-checking bench for the sinc3 decimation block
`timescale 1ns/100ps
`include "sdc_defines.vh"
module tb_top;
    localparam NCH = 2;
    reg               clk, sys_rst, hsel, hwrite, rdPend;
    reg  [31:0]       haddr, hwdata, seed;
    reg  [1:0]        htrans;
    reg  [2:0]        hsize, g0, g1, m0, m1;
    reg  [NCH-1:0]    level;
    wire              hready, hreadyout, hresp, modSampleEn, refBufferPowerdownN, dataReady;
    wire [31:0]       hrdata;
    wire [NCH-1:0]    modBit, chanBiasMeasure;
    wire [3*NCH-1:0]  chanGain, chanMux;
    integer           fails, n_checks, cyc, samp, i, c, n, t0, t1, s1;
    logic [31:0]      expQ[$];
    string            nameQ[$];
    assign hready = hreadyout;
    sdc_top #(.NCH(NCH)) sdc_top_i (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .modBit(modBit), .modSampleEn(modSampleEn), .chanGain(chanGain), .chanMux(chanMux),
        .chanBiasMeasure(chanBiasMeasure), .refBufferPowerdownN(refBufferPowerdownN), .dataReady(dataReady));
    sdc_mod_model #(.NCH(NCH)) sdc_mod_model_i (.modSampleEn(modSampleEn), .level(level), .modBit(modBit));
    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    function [31:0] rnd;
        begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            rnd = seed;
        end
    endfunction
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            n_checks = n_checks + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("MISMATCH %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", n_checks, fails);
            if (fails == 0 && n_checks > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    task waitRdy;
        begin
            @(posedge clk);
            while (hreadyout !== 1'b1) @(posedge clk);
        end
    endtask
    task waitDr;
        begin
            @(posedge clk);
            while (dataReady !== 1'b1) @(posedge clk);
        end
    endtask
    // single write: address phase, then data phase
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            hsel <= 1'b1;
            htrans <= 2'h2;
            hwrite <= 1'b1;
            haddr <= {24'h000000, a};
            waitRdy;
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            waitRdy;
        end
    endtask
    // single read: expectation queued, monitor compares at the data-phase edge
    task rd(input [7:0] a, input [31:0] e, input string nm);
        begin
            @(posedge clk);
            hsel <= 1'b1;
            htrans <= 2'h2;
            hwrite <= 1'b0;
            haddr <= {24'h000000, a};
            waitRdy;
            hsel <= 1'b0;
            htrans <= 2'h0;
            rdPend <= 1'b1;
            expQ.push_back(e);
            nameQ.push_back(nm);
            waitRdy;
            rdPend <= 1'b0;
        end
    endtask
    // monitor: cycle and strobe counts, read data against the oldest note
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (modSampleEn === 1'b1) samp <= samp + 1;
        if (rdPend === 1'b1) chk(nameQ.pop_front(), expQ.pop_front(), hrdata);
    end
    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        fails = fails + 1;
        close_out;
    end
    // main sequence
    initial begin
        {hsel, hwrite, rdPend, htrans, haddr, hwdata} = 0;
        hsize = 3'h2;
        level = 2'b01;
        seed = 32'h9;
        {fails, n_checks, cyc, samp} = 0;
        sys_rst = 1'b1;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk("refbuf", 32'h0, refBufferPowerdownN);
        chk("gain", {NCH{3'h6}}, chanGain);
        chk("mux", 32'h0, chanMux);
        rd(`SDC_OFS_SETUP_ONE, 32'h6, "rate");
        rd(`SDC_OFS_CHAN_BASE + 8'h04, {25'h0, `SDC_CHAN_RESET}, "chan1");
        rd(8'h10, 32'h0, "unmapped");
        $display("test reset done");
        for (i = 0; i < 4; i = i + 1) begin
            g0 = rnd() % 7;
            g1 = rnd() % 7;
            m0 = rnd();
            m1 = (i == 3) ? 3'h2 : rnd();
            wr(`SDC_OFS_CHAN_BASE, {25'h0, g0, 1'b0, m0});
            wr(`SDC_OFS_CHAN_BASE + 8'h04, {25'h0, g1, 1'b0, m1});
            @(posedge clk);
            chk("gain", {g1, g0}, chanGain);
            chk("mux", {m1, m0}, chanMux);
            rd(`SDC_OFS_CHAN_BASE, {25'h0, g0, 1'b0, m0}, "chan0");
        end
        wr(`SDC_OFS_SETUP_THREE, 32'h3);
        @(posedge clk);
        chk("refbuf", 32'h1, refBufferPowerdownN);
        chk("bias", {m1 == 3'h2, m0 == 3'h2}, chanBiasMeasure);
        wr(`SDC_OFS_SETUP_THREE, 32'h1);
        @(posedge clk);
        chk("bias off", 32'h0, chanBiasMeasure);
        rd(`SDC_OFS_SETUP_THREE, 32'h1, "setup3");
        $display("test config done");
        wr(`SDC_OFS_SETUP_ONE, 32'h7);
        wr(`SDC_OFS_CONTROL, 32'h1);
        rd(`SDC_OFS_STATUS, 32'h4, "bad rate");
        wr(`SDC_OFS_CONTROL, 32'h0);
        $display("test bad rate done");
        for (c = 0; c < 3; c = c + 1) begin
            n = 64 << c;
            level <= 2'b01;
            wr(`SDC_OFS_SETUP_ONE, c);
            wr(`SDC_OFS_CONTROL, 32'h1);
            t0 = cyc;
            wr(`SDC_OFS_SETUP_ONE, 32'h6);
            waitDr;
            t1 = cyc;
            s1 = samp;
            chk("first word late enough", 32'h1, (t1 - t0 >= 8 * n) && (t1 - t0 <= 8 * n + 64));
            waitDr;
            chk("period clocks", 2 * n, cyc - t1);
            chk("samples per word", n, samp - s1);
            rd(`SDC_OFS_DATA_BASE, 32'h007FFFFF, "ch0 plus");
            rd(`SDC_OFS_DATA_BASE + 8'h04, 32'h00800000, "ch1 minus");
            level <= 2'b10;
            repeat (4) waitDr;
            rd(`SDC_OFS_DATA_BASE, 32'h00800000, "ch0 step");
            rd(`SDC_OFS_DATA_BASE + 8'h04, 32'h007FFFFF, "ch1 step");
            // six stored periods per rate so far: running and settled, no bad rate
            rd(`SDC_OFS_STATUS, (6 * c + 6) * 32'h10000 + 32'h3, "status run");
            wr(`SDC_OFS_CONTROL, 32'h0);
            $display("test rate %0d done", c);
        end
        close_out;
    end
endmodule // tb_top
